// ===== bench/arhc_top_chk.sv
// Purpose: Port assertions for arhc_top
// Assumes: One clock, async active-high reset
// Notes:   Bound after the module
`timescale 1ns/1ps

module arhc_chk (
	input wire logic                   clk,
	input wire logic                   rst,
	input wire arhc_pkg::arhc_bus_s    bus,
	input wire logic [7:0]             rd_data,
	input wire arhc_pkg::arhc_mode_e   low_noise_low_power_mode,
	input wire logic [2:0]             active_rate_field,
	input wire logic [1:0]             sleep_rate_field,
	input wire logic                   auto_sleep_active,
	input wire arhc_pkg::arhc_sample_s sample_in,
	input wire arhc_pkg::arhc_out_s    out_sample,
	input wire arhc_pkg::arhc_sample_s tap_sample,
	input wire arhc_pkg::arhc_info_s   info
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// ==========================================================================
	// Sequences
	sequence s_take;
		sample_in.valid;
	endsequence
	sequence s_raw_tap;
		s_take ##0 (info.tap_hpf_bypass && !info.tap_lpf_en);
	endsequence

	// ==========================================================================
	// Assertions
	rd_idle_a: assert property (!$past(bus.re) |-> rd_data == 8'h00)
		else $error("read data outside read slot");
	rd_unmapped_a: assert property ($past(bus.re) && !($past(bus.addr) inside {8'h0e, 8'h0f})
		|-> rd_data == 8'h00) else $error("unmapped read not zero");
	out_valid_a: assert property (s_take |=> out_sample.valid)
		else $error("no output after sample");
	no_spur_a: assert property (!sample_in.valid |=> !out_sample.valid && !tap_sample.valid)
		else $error("spurious valid");
	axes_hold_a: assert property (!sample_in.valid |=> $stable(out_sample.axis))
		else $error("output axes moved");
	sens_4g_a: assert property (info.range_select == 2'h1 |->
		info.full_scale_g == 4'h4 && info.sens_ug_per_count == 16'h01e8) else $error("4g scale");
	sens_8g_a: assert property (info.range_select == 2'h2 |->
		info.full_scale_g == 4'h8 && info.sens_ug_per_count == 16'h03d0) else $error("8g scale");
	rate_sleep_a: assert property (auto_sleep_active |=>
		info.output_sample_rate == {1'b1, $past(sleep_rate_field)}) else $error("sleep rate");
	tap_raw_a: assert property (s_raw_tap |=> tap_sample.valid &&
		tap_sample.axis == $past(sample_in.axis)) else $error("tap bypass data");
endmodule : arhc_chk

bind arhc_top arhc_chk chk_i (.clk(clk), .rst(rst), .bus(bus), .rd_data(rd_data),
	.low_noise_low_power_mode(low_noise_low_power_mode), .active_rate_field(active_rate_field),
	.sleep_rate_field(sleep_rate_field), .auto_sleep_active(auto_sleep_active),
	.sample_in(sample_in), .out_sample(out_sample), .tap_sample(tap_sample), .info(info));

// ===== bench/test_accel_range_hpf_config.sv
// Purpose: Self-checking bench for arhc_top
// Assumes: Bench model of registers, scaling and tap smoothing
// Notes:   Seeded random stimulus
`timescale 1ns/1ps

module test_accel_range_hpf_config;
	logic                   clk, rst, asl;
	arhc_pkg::arhc_bus_s    bus;
	logic [7:0]             rd_data, m0e, m0f, d;
	arhc_pkg::arhc_mode_e   mode;
	logic [2:0]             act;
	logic [1:0]             slp;
	arhc_pkg::arhc_sample_s sin, tap;
	arhc_pkg::arhc_out_s    sout;
	arhc_pkg::arhc_info_s   info;
	int                     miscompares, tests_run, tl[3], hl[3], rl[8];
	logic [31:0]            cx[4];

	arhc_top dut (.clk(clk), .rst(rst), .bus(bus), .rd_data(rd_data),
		.low_noise_low_power_mode(mode), .active_rate_field(act), .sleep_rate_field(slp),
		.auto_sleep_active(asl), .sample_in(sin), .out_sample(sout), .tap_sample(tap),
		.info(info));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================================================
	// Helpers
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	function automatic int sat(int x);
		return x > 8191 ? 8191 : (x < -8192 ? -8192 : x);
	endfunction : sat

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk) bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk) bus.we <= 1'b0;
		if (a == 8'h0e) m0e = v & 8'h13;
		if (a == 8'h0f) m0f = v & 8'h33;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk) bus.re <= 1'b0;
		#1 chk("rd_data", rd_data, e);
	endtask : rd

	task ci;
		logic [2:0]  rt;
		logic [3:0]  fsg;
		logic [15:0] se;
		rt = asl ? {1'b1, slp} : act;
		fsg = m0e[1:0] == 2'h1 ? 4'h4 : (m0e[1:0] == 2'h2 ? 4'h8 : 4'h2);
		se = m0e[1:0] == 2'h1 ? 16'h01e8 : (m0e[1:0] == 2'h2 ? 16'h03d0 : 16'h00f4);
		repeat (2) @(posedge clk);
		#1 chk("info", info, {m0e[4], m0e[1:0], fsg, se, rt, cx[mode][rt*4 +: 4] + m0f[1:0],
			m0f[5], m0f[4]});
	endtask : ci

	task smp(input int amp);
		int                 v[3];
		int                 sh, hs, df, src;
		logic [2:0]         rt;
		logic signed [15:0] hp;
		rt = asl ? {1'b1, slp} : act;
		sh = m0e[1:0] == 2'h1 ? 1 : (m0e[1:0] == 2'h2 ? 2 : 0);
		hs = 3 + int'(cx[mode][rt*4 +: 4] + m0f[1:0]) - rl[rt];
		hs = hs < 1 ? 1 : (hs > 15 ? 15 : hs);
		foreach (v[i]) v[i] = amp ? int'($urandom_range(2 * amp - 1)) - amp : 8000;
		@(posedge clk) sin <= {1'b1, 16'(v[2]), 16'(v[1]), 16'(v[0])};
		@(posedge clk) sin.valid <= 1'b0;
		#1 chk("valid", {sout.valid, tap.valid}, 2'b11);
		for (int i = 0; i < 3; i++) begin
			df = v[i] * 256 - hl[i];
			hp = 16'(df >>> 8);
			hl[i] += df >>> hs;
			src = m0f[5] ? v[i] : int'(hp);
			tl[i] = m0f[4] ? tl[i] + ((src - tl[i]) >>> 2) : src;
			chk("out", sout.axis[i], 14'(sat((m0e[4] ? int'(hp) : v[i]) >>> sh)));
			chk("tap", tap.axis[i], 16'(tl[i]));
		end
	endtask : smp

	// ==========================================================================
	// Tests
	initial begin
		void'($urandom(52));
		{rst, asl, act, slp, m0e, m0f} = {1'b1, 22'h0};
		mode = arhc_pkg::ARHC_MODE_NORMAL;
		bus = '0;
		sin = '0;
		tl = '{0, 0, 0};
		hl = '{0, 0, 0};
		cx = '{32'h3333_2100, 32'h8653_2100, 32'h0000_0000, 32'h9764_3210};
		rl = '{0, 1, 2, 3, 4, 6, 7, 9};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(8'h0e, 8'h00);
		rd(8'h0f, 8'h00);
		ci;
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			d = 8'($urandom);
			wr(8'h0e, d);
			rd(8'h0e, m0e);
			wr(8'h0f, ~d);
			rd(8'h0f, m0f);
			wr(8'h10 + 8'(i), d);
			rd(8'h10 + 8'(i), 8'h00);
		end
		$display("register test done");
		for (int i = 0; i < 32; i++) begin
			@(posedge clk);
			mode <= arhc_pkg::arhc_mode_e'(2'(i >> 3));
			act <= 3'(i);
			{asl, slp} <= 3'($urandom);
			wr(8'h0f, 8'($urandom));
			ci;
		end
		$display("cutoff test done");
		wr(8'h0f, 8'h20);
		for (int r = 0; r < 4; r++) begin
			wr(8'h0e, 8'(r));
			ci;
			repeat (3) smp(32768);
		end
		$display("range test done");
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		{m0e, m0f} = 16'h0000;
		hl = '{0, 0, 0};
		tl = '{0, 0, 0};
		@(posedge clk) mode <= arhc_pkg::ARHC_MODE_HIRES;
		{act, asl} <= 4'h0;
		rd(8'h0f, 8'h00);
		wr(8'h0e, 8'h10);
		ci;
		repeat (4) smp(0);
		chk("hpf", sout.axis[0] != 14'sd8000 && tap.axis[0] != 16'sd8000, 1'b1);
		$display("highpass test done");
		wr(8'h0e, 8'h00);
		wr(8'h0f, 8'h30);
		repeat (6) smp(4000);
		$display("tap test done");
		complete_run;
	end

	initial begin
		#200us;
		miscompares++;
		complete_run;
	end
endmodule : test_accel_range_hpf_config

// ===== verilog/arhc_cutoff.sv
// Purpose: Corner exponent and rate exponent from rate, mode and cutoff code
// Assumes: Corner = 16 Hz / 2^cutoff_exp
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "arhc_defines.svh"

module arhc_cutoff (
	input  wire logic [2:0]          rate_code,
	input  wire arhc_pkg::arhc_mode_e mode,
	input  wire logic [1:0]          sel,
	output logic      [3:0]          cutoff_exp,
	output logic      [3:0]          rate_log
);

	logic [3:0] base_exp;

	// ==========================================================================
	// Rate exponent
	always_comb begin
		case (rate_code)
			3'h0:    rate_log = 4'h0;
			3'h1:    rate_log = 4'h1;
			3'h2:    rate_log = 4'h2;
			3'h3:    rate_log = 4'h3;
			3'h4:    rate_log = 4'h4;
			3'h5:    rate_log = 4'h6;
			3'h6:    rate_log = 4'h7;
			default: rate_log = 4'h9;
		endcase
	end

	// ==========================================================================
	// Mode and rate scaling
	always_comb begin
		case (mode)
			arhc_pkg::ARHC_MODE_HIRES: base_exp = 4'h0;
			arhc_pkg::ARHC_MODE_NORMAL: begin
				case (rate_code)
					3'h0, 3'h1: base_exp = 4'h0;
					3'h2:       base_exp = 4'h1;
					3'h3:       base_exp = 4'h2;
					default:    base_exp = 4'h3;
				endcase
			end
			arhc_pkg::ARHC_MODE_LOWNOISE: begin
				case (rate_code)
					3'h0, 3'h1: base_exp = 4'h0;
					3'h2:       base_exp = 4'h1;
					3'h3:       base_exp = 4'h2;
					3'h4:       base_exp = 4'h3;
					3'h5:       base_exp = 4'h5;
					3'h6:       base_exp = 4'h6;
					default:    base_exp = 4'h8;
				endcase
			end
			default: begin
				case (rate_code)
					3'h5:    base_exp = 4'h6;
					3'h6:    base_exp = 4'h7;
					3'h7:    base_exp = 4'h9;
					default: base_exp = {1'b0, rate_code};
				endcase
			end
		endcase
	end

	assign cutoff_exp = base_exp + {2'b00, sel};

endmodule : arhc_cutoff

// ===== verilog/arhc_defines.svh
// Purpose: Offsets, field positions, reset values and constants of the range/high-pass config
// Assumes: Included by bare name; definitions only
// Notes:   Rates coded 0..7 = 800, 400, 200, 100, 50, 12.5, 6.25, 1.56 Hz
// How it works
// - Output high-pass select bit gates filtering
// - Range field picks 2, 4 or 8 g
// - Count weight follows the selected range
// - Tap bypass bit picks raw or filtered
// - Tap low-pass bit inserts smoothing stage
// - Cutoff field halves corner per code step
// - Corner scales with rate and oversampling mode
// - Sleep rate used while auto-sleep active
`ifndef ARHC_DEFINES_SVH
`define ARHC_DEFINES_SVH

// ==========================================================================
// Register map
`define ARHC_ADDR_RANGE_CFG   8'h0e
`define ARHC_ADDR_CUTOFF_CFG  8'h0f
`define ARHC_RANGE_CFG_RST    8'h00
`define ARHC_CUTOFF_CFG_RST   8'h00
`define ARHC_RANGE_CFG_MASK   8'h13
`define ARHC_CUTOFF_CFG_MASK  8'h33
`define ARHC_RD_UNMAPPED      8'h00

// ==========================================================================
// Field positions
`define ARHC_HPF_OUT_BIT      4
`define ARHC_RANGE_SEL_MSB    1
`define ARHC_RANGE_SEL_LSB    0
`define ARHC_TAP_HPF_BYP_BIT  5
`define ARHC_TAP_LPF_EN_BIT   4
`define ARHC_CUTOFF_SEL_MSB   1
`define ARHC_CUTOFF_SEL_LSB   0

// ==========================================================================
// Range codes and scaling
`define ARHC_RANGE_2G         2'h0
`define ARHC_RANGE_4G         2'h1
`define ARHC_RANGE_8G         2'h2
`define ARHC_FULL_2G          4'h2
`define ARHC_FULL_4G          4'h4
`define ARHC_FULL_8G          4'h8
`define ARHC_SENS_2G_UG       16'h00f4
`define ARHC_SENS_4G_UG       16'h01e8
`define ARHC_SENS_8G_UG       16'h03d0
`define ARHC_OUT_MAX          16'sh1fff
`define ARHC_OUT_MIN          -16'sh2000

// ==========================================================================
// Filter constants
`define ARHC_HPF_BASE_SHIFT   6'sh03
`define ARHC_HPF_MIN_SHIFT    4'h1
`define ARHC_HPF_MAX_SHIFT    4'hf
`define ARHC_TAP_LPF_SHIFT    2
`define ARHC_ACC_FRAC         8
`define ARHC_SLEEP_RATE_BASE  1'h1

`endif

// ===== verilog/arhc_pkg.sv
// Purpose: Types of the range/high-pass config block
// Assumes: Used by scoped name only
// Notes:   Input samples weigh 0.244 mg per count
package arhc_pkg;

	// ==========================================================================
	// Oversampling modes
	typedef enum logic [1:0] {
		ARHC_MODE_NORMAL = 2'b00,
		ARHC_MODE_LOWNOISE = 2'b01,
		ARHC_MODE_HIRES  = 2'b10,
		ARHC_MODE_LOWPWR = 2'b11
	} arhc_mode_e;

	// ==========================================================================
	// Carriers
	typedef logic signed [15:0] arhc_axis_t;
	typedef logic signed [13:0] arhc_out_t;
	typedef logic signed [23:0] arhc_acc_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} arhc_bus_s;

	typedef struct packed {
		logic                  valid;
		arhc_axis_t [2:0]      axis;
	} arhc_sample_s;

	typedef struct packed {
		logic                  valid;
		arhc_out_t [2:0]       axis;
	} arhc_out_s;

	typedef struct packed {
		logic        hpf_out_en;
		logic [1:0]  range_select;
		logic [3:0]  full_scale_g;
		logic [15:0] sens_ug_per_count;
		logic [2:0]  output_sample_rate;
		logic [3:0]  cutoff_exp;
		logic        tap_hpf_bypass;
		logic        tap_lpf_en;
	} arhc_info_s;

	typedef struct packed {
		logic [7:0]       range_cfg;
		logic [7:0]       cutoff_cfg;
		logic [7:0]       rd_data;
		arhc_acc_t [2:0]  hp_lp;
		arhc_axis_t [2:0] tap_lp;
		arhc_out_s        out;
		arhc_sample_s     tap;
		arhc_info_s       info;
	} arhc_state_s;

endpackage : arhc_pkg

// ===== verilog/arhc_top.sv
// Purpose: Range select, output high-pass filter and tap path configuration
// Assumes: Input samples at 0.244 mg per count, one valid strobe per sample
// Notes:   Registers reached over a plain address/strobe port
`timescale 1ns/1ps
`include "arhc_defines.svh"

module arhc_top (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire arhc_pkg::arhc_bus_s   bus,
	output logic      [7:0]            rd_data,
	input  wire arhc_pkg::arhc_mode_e  low_noise_low_power_mode,
	input  wire logic [2:0]            active_rate_field,
	input  wire logic [1:0]            sleep_rate_field,
	input  wire logic                  auto_sleep_active,
	input  wire arhc_pkg::arhc_sample_s sample_in,
	output arhc_pkg::arhc_out_s        out_sample,
	output arhc_pkg::arhc_sample_s     tap_sample,
	output arhc_pkg::arhc_info_s       info
);

	// ==========================================================================
	// State
	arhc_pkg::arhc_state_s state_reg;
	arhc_pkg::arhc_state_s state_next;

	logic [2:0]              rate_code;
	logic [3:0]              cutoff_exp;
	logic [3:0]              rate_log;
	logic signed [5:0]       shift_raw;
	logic [3:0]              hp_shift;
	logic                    hpf_out_en;
	logic [1:0]              range_sel;
	logic                    tap_byp;
	logic                    tap_lpf;

	arhc_pkg::arhc_acc_t  [2:0] lp_upd;
	arhc_pkg::arhc_axis_t [2:0] hp_val;
	arhc_pkg::arhc_axis_t [2:0] tap_src;
	arhc_pkg::arhc_axis_t [2:0] tap_upd;
	arhc_pkg::arhc_axis_t [2:0] tap_val;
	arhc_pkg::arhc_out_t  [2:0] scaled;

	// ==========================================================================
	// Saturate to output width
	function automatic arhc_pkg::arhc_out_t sat14(input logic signed [15:0] v);
		arhc_pkg::arhc_out_t r;
		if (v > `ARHC_OUT_MAX) begin
			r = 14'h1fff;
		end else if (v < `ARHC_OUT_MIN) begin
			r = 14'h2000;
		end else begin
			r = v[13:0];
		end
		return r;
	endfunction : sat14

	// ==========================================================================
	// Configuration fields
	assign hpf_out_en = state_reg.range_cfg[`ARHC_HPF_OUT_BIT];
	assign range_sel  = state_reg.range_cfg[`ARHC_RANGE_SEL_MSB:`ARHC_RANGE_SEL_LSB];
	assign tap_byp    = state_reg.cutoff_cfg[`ARHC_TAP_HPF_BYP_BIT];
	assign tap_lpf    = state_reg.cutoff_cfg[`ARHC_TAP_LPF_EN_BIT];

	assign rate_code = auto_sleep_active ? {`ARHC_SLEEP_RATE_BASE, sleep_rate_field}
		: active_rate_field;

	arhc_cutoff u_cutoff (
		.rate_code  (rate_code),
		.mode       (low_noise_low_power_mode),
		.sel        (state_reg.cutoff_cfg[`ARHC_CUTOFF_SEL_MSB:`ARHC_CUTOFF_SEL_LSB]),
		.cutoff_exp (cutoff_exp),
		.rate_log   (rate_log)
	);

	// ==========================================================================
	// Filter time constant
	assign shift_raw = `ARHC_HPF_BASE_SHIFT + $signed({2'b00, cutoff_exp})
		- $signed({2'b00, rate_log});

	always_comb begin
		if (shift_raw < $signed({2'b00, `ARHC_HPF_MIN_SHIFT})) begin
			hp_shift = `ARHC_HPF_MIN_SHIFT;
		end else if (shift_raw > $signed({2'b00, `ARHC_HPF_MAX_SHIFT})) begin
			hp_shift = `ARHC_HPF_MAX_SHIFT;
		end else begin
			hp_shift = shift_raw[3:0];
		end
	end

	// ==========================================================================
	// Per-axis datapath
	genvar i;
	generate
		for (i = 0; i < 3; i++) begin : g_axis
			logic signed [24:0] in_acc;
			logic signed [24:0] diff;
			logic signed [24:0] step;
			logic signed [15:0] src_out;
			logic signed [15:0] shifted;
			logic signed [16:0] tap_diff;
			logic signed [16:0] tap_step;

			// High-pass: input minus tracked low-pass
			assign in_acc = {sample_in.axis[i][15], sample_in.axis[i], 8'h00};
			assign diff   = in_acc - {state_reg.hp_lp[i][23], state_reg.hp_lp[i]};
			assign step   = diff >>> hp_shift;
			assign lp_upd[i] = state_reg.hp_lp[i] + step[23:0];
			assign hp_val[i] = diff[`ARHC_ACC_FRAC+15:`ARHC_ACC_FRAC];

			assign src_out = hpf_out_en ? hp_val[i] : sample_in.axis[i];

			always_comb begin
				case (range_sel)
					`ARHC_RANGE_4G: shifted = src_out >>> 1;
					`ARHC_RANGE_8G: shifted = src_out >>> 2;
					default:        shifted = src_out;
				endcase
			end

			assign scaled[i] = sat14(shifted);

			assign tap_src[i] = tap_byp ? sample_in.axis[i] : hp_val[i];

			assign tap_diff   = {tap_src[i][15], tap_src[i]}
				- {state_reg.tap_lp[i][15], state_reg.tap_lp[i]};
			assign tap_step   = tap_diff >>> `ARHC_TAP_LPF_SHIFT;
			assign tap_upd[i] = state_reg.tap_lp[i] + tap_step[15:0];
			assign tap_val[i] = tap_lpf ? tap_upd[i] : tap_src[i];
		end
	endgenerate

	// ==========================================================================
	// Next state
	always_comb begin
		state_next = state_reg;

		// Register writes, reserved bits dropped
		if (bus.we) begin
			if (bus.addr == `ARHC_ADDR_RANGE_CFG) begin
				state_next.range_cfg = bus.wdata & `ARHC_RANGE_CFG_MASK;
			end else if (bus.addr == `ARHC_ADDR_CUTOFF_CFG) begin
				state_next.cutoff_cfg = bus.wdata & `ARHC_CUTOFF_CFG_MASK;
			end
		end

		// Read data for one cycle only
		state_next.rd_data = `ARHC_RD_UNMAPPED;
		if (bus.re) begin
			if (bus.addr == `ARHC_ADDR_RANGE_CFG) begin
				state_next.rd_data = state_reg.range_cfg;
			end else if (bus.addr == `ARHC_ADDR_CUTOFF_CFG) begin
				state_next.rd_data = state_reg.cutoff_cfg;
			end
		end

		// Sample strobes
		state_next.out.valid = sample_in.valid;
		state_next.tap.valid = sample_in.valid;
		if (sample_in.valid) begin
			state_next.hp_lp    = lp_upd;
			state_next.out.axis = scaled;
			state_next.tap.axis = tap_val;
			if (tap_lpf) begin
				state_next.tap_lp = tap_upd;
			end else begin
				state_next.tap_lp = tap_src;
			end
		end

		// Status view of configuration
		state_next.info.hpf_out_en         = hpf_out_en;
		state_next.info.range_select       = range_sel;
		state_next.info.output_sample_rate = rate_code;
		state_next.info.cutoff_exp         = cutoff_exp;
		state_next.info.tap_hpf_bypass     = tap_byp;
		state_next.info.tap_lpf_en         = tap_lpf;
		case (range_sel)
			`ARHC_RANGE_4G: begin
				state_next.info.full_scale_g      = `ARHC_FULL_4G;
				state_next.info.sens_ug_per_count = `ARHC_SENS_4G_UG;
			end
			`ARHC_RANGE_8G: begin
				state_next.info.full_scale_g      = `ARHC_FULL_8G;
				state_next.info.sens_ug_per_count = `ARHC_SENS_8G_UG;
			end
			default: begin
				state_next.info.full_scale_g      = `ARHC_FULL_2G;
				state_next.info.sens_ug_per_count = `ARHC_SENS_2G_UG;
			end
		endcase
	end

	// ==========================================================================
	// Registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg            <= '0;
			state_reg.range_cfg  <= `ARHC_RANGE_CFG_RST;
			state_reg.cutoff_cfg <= `ARHC_CUTOFF_CFG_RST;
			state_reg.info.full_scale_g      <= `ARHC_FULL_2G;
			state_reg.info.sens_ug_per_count <= `ARHC_SENS_2G_UG;
		end else begin
			state_reg <= state_next;
		end
	end

	// ==========================================================================
	// Outputs
	assign rd_data    = state_reg.rd_data;
	assign out_sample = state_reg.out;
	assign tap_sample = state_reg.tap;
	assign info       = state_reg.info;

endmodule : arhc_top
